//--- verilog/cpusv_pkg.sv
// Package with timing and width constants for the processor supervisor
package cpusv_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned RESET_STRETCH_MS = 250;
  localparam int unsigned DEBOUNCE_MS      = 10;
  localparam int unsigned WATCHDOG_MS      = 1500;
  localparam int unsigned TICK_HZ          = 1000;
  localparam int unsigned TICK_DIV         = CLK_HZ / TICK_HZ;
  localparam int unsigned STRETCH_TICKS    = RESET_STRETCH_MS * TICK_HZ / 1000;
  localparam int unsigned DEBOUNCE_TICKS   = DEBOUNCE_MS * TICK_HZ / 1000;
  localparam int unsigned WATCHDOG_TICKS   = WATCHDOG_MS * TICK_HZ / 1000;
  localparam int unsigned CNT_W            = 16;
  localparam int unsigned DIV_W            = 16;
  typedef enum logic [1:0] {
    CPUSV_RUN,
    CPUSV_HOLD,
    CPUSV_STRETCH
  } cpusv_state_t;
endpackage

//--- verilog/cpusv_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module cpusv_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1   <= INIT;
      sync_out <= INIT;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

//--- verilog/cpusv_supervisor.sv
// Processor supervisor: power-fail reset, pushbutton, watchdog, SRAM gating
// Functional notes
// R1 - Power-fail active holds processor reset asserted
// R2 - After power-fail clears, reset stays asserted a further 250 ms
// R3 - Debounced pushbutton press gives a reset pulse of at least 250 ms
// R4 - Watchdog expiry without low strobe asserts processor reset
// R5 - SRAM chip-enables forced inactive during power-fail
// R6 - Host pulses strobe low within every watchdog period
// R7 - Reset pin doubles as pushbutton input, open-drain driven low
// R8 - High-byte enable out low only when select and high enable low
// R9 - Low-byte enable out low only when select and low enable low
// R10 - Watchdog length is a parameter; restarts on strobe or reset end
`timescale 1ns/10ps
module cpusv_supervisor
  import cpusv_pkg::*;
#(
  parameter int unsigned TICK_DIVIDE    = TICK_DIV,
  parameter int unsigned STRETCH_COUNT  = STRETCH_TICKS,
  parameter int unsigned DEBOUNCE_COUNT = DEBOUNCE_TICKS,
  parameter int unsigned WATCHDOG_COUNT = WATCHDOG_TICKS
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Supply monitor
  input  wire logic power_fail,
  // Processor reset pin, open drain
  input  wire logic cpu_reset_n_in,
  output logic      cpu_reset_n_out,
  output logic      cpu_reset_n_oe,
  // Watchdog strobe
  input  wire logic watchdog_strobe_n,
  // SRAM chip-enable gating
  input  wire logic ram_select_in_n,
  input  wire logic upper_byte_enable_n,
  input  wire logic lower_byte_enable_n,
  output logic      ram_select_high_out_n,
  output logic      ram_select_low_out_n
);
  initial begin
    if (TICK_DIVIDE < 4 || TICK_DIVIDE >= (1 << DIV_W)) $error("bad TICK_DIVIDE");
    if (STRETCH_COUNT < 1 || STRETCH_COUNT >= (1 << CNT_W)) $error("bad STRETCH_COUNT");
    if (DEBOUNCE_COUNT < 2 || DEBOUNCE_COUNT >= STRETCH_COUNT) $error("bad DEBOUNCE_COUNT");
    if (WATCHDOG_COUNT < 2 || WATCHDOG_COUNT >= (1 << CNT_W)) $error("bad WATCHDOG_COUNT");
  end

  localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(TICK_DIVIDE - 1);
  localparam logic [CNT_W-1:0] STR_LAST  = CNT_W'(STRETCH_COUNT);
  localparam logic [CNT_W-1:0] DEB_LAST  = CNT_W'(DEBOUNCE_COUNT);
  localparam logic [CNT_W-1:0] WDOG_LAST = CNT_W'(WATCHDOG_COUNT);

  // Synchronised pin inputs
  logic [5:0] pins_sync;
  logic       pf_s;
  logic       rst_pin_s;
  logic       strobe_s;
  logic       sel_s;
  logic       ub_s;
  logic       lb_s;

  cpusv_sync #(.WIDTH(6), .INIT(6'h3f)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({~power_fail, cpu_reset_n_in, watchdog_strobe_n,
                ram_select_in_n, upper_byte_enable_n, lower_byte_enable_n}),
    .sync_out (pins_sync)
  );

  assign pf_s      = ~pins_sync[5];
  assign rst_pin_s = pins_sync[4];
  assign strobe_s  = pins_sync[3];
  assign sel_s     = pins_sync[2];
  assign ub_s      = pins_sync[1];
  assign lb_s      = pins_sync[0];

  // Millisecond tick divider
  logic [DIV_W-1:0] div_cnt;
  logic             tick;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= (div_cnt == DIV_LAST);
      div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
    end
  end

  // Main reset state
  cpusv_state_t     state;
  logic [CNT_W-1:0] str_cnt;
  logic [CNT_W-1:0] deb_cnt;
  logic [CNT_W-1:0] wdog_cnt;
  logic             button_press;
  logic             wdog_expire;
  logic             reset_done;

  // Debounce: pin low for DEBOUNCE_COUNT ticks while not driving it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      deb_cnt <= '0;
    end else if (rst_pin_s || state != CPUSV_RUN) begin
      deb_cnt <= '0;
    end else if (tick && deb_cnt != DEB_LAST) begin
      deb_cnt <= deb_cnt + 1'b1; // R7
    end
  end

  assign button_press = (state == CPUSV_RUN) && (deb_cnt == DEB_LAST); // R3 R7

  // Watchdog counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wdog_cnt <= '0;
    end else if (state != CPUSV_RUN || !strobe_s) begin
      wdog_cnt <= '0; // R10
    end else if (tick && wdog_cnt != WDOG_LAST) begin
      wdog_cnt <= wdog_cnt + 1'b1; // R4
    end
  end

  assign wdog_expire = (state == CPUSV_RUN) && (wdog_cnt == WDOG_LAST); // R4
  assign reset_done  = (state == CPUSV_STRETCH) && (str_cnt == STR_LAST);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state   <= CPUSV_HOLD;
      str_cnt <= '0;
    end else if (pf_s) begin
      state   <= CPUSV_HOLD; // R1
      str_cnt <= '0;
    end else begin
      unique case (state)
        CPUSV_HOLD: begin
          state   <= CPUSV_STRETCH; // R2
          str_cnt <= '0;
        end
        CPUSV_STRETCH: begin
          if (reset_done) begin
            state <= CPUSV_RUN; // R2 R3
          end else if (tick) begin
            str_cnt <= str_cnt + 1'b1;
          end
        end
        CPUSV_RUN: begin
          if (button_press || wdog_expire) begin
            state   <= CPUSV_STRETCH; // R3 R4
            str_cnt <= '0;
          end
        end
      endcase
    end
  end

  // Open-drain reset drive: output always low, enable while asserting
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_reset_n_out <= 1'b0;
      cpu_reset_n_oe  <= 1'b1;
    end else begin
      cpu_reset_n_out <= 1'b0;
      cpu_reset_n_oe  <= pf_s || (state != CPUSV_RUN) || button_press || wdog_expire; // R1 R7
    end
  end

  // SRAM chip-enable gating
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ram_select_high_out_n <= 1'b1;
      ram_select_low_out_n  <= 1'b1;
    end else begin
      ram_select_high_out_n <= pf_s | sel_s | ub_s; // R5 R8
      ram_select_low_out_n  <= pf_s | sel_s | lb_s; // R5 R9
    end
  end

  // Assertions
  int unsigned asrt_low;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      asrt_low <= 0;
    end else if (!cpu_reset_n_oe) begin
      asrt_low <= 0;
    end else if (tick) begin
      asrt_low <= asrt_low + 1;
    end
  end

  chk_pf_holds_reset: assert property (@(posedge clk) disable iff (reset) // R1
    pf_s |=> cpu_reset_n_oe) else $error("reset not held during power fail");
  chk_stretch_length: assert property (@(posedge clk) disable iff (reset) // R2
    $fell(cpu_reset_n_oe) |-> $past(asrt_low) >= STRETCH_COUNT)
    else $error("reset pulse shorter than stretch");
  chk_button_reset: assert property (@(posedge clk) disable iff (reset) // R3
    button_press && !pf_s |=> cpu_reset_n_oe && state == CPUSV_STRETCH)
    else $error("button press did not start reset");
  chk_wdog_reset: assert property (@(posedge clk) disable iff (reset) // R4
    wdog_expire && !pf_s |=> cpu_reset_n_oe ##0 state == CPUSV_STRETCH)
    else $error("watchdog expiry did not reset");
  chk_pf_ram_off: assert property (@(posedge clk) disable iff (reset) // R5
    pf_s |=> ram_select_high_out_n && ram_select_low_out_n)
    else $error("ram enabled during power fail");
  chk_od_drive_low: assert property (@(posedge clk) disable iff (reset) // R7
    cpu_reset_n_out == 1'b0 && (cpu_reset_n_oe || state == CPUSV_RUN))
    else $error("open drain drove high or released outside run");
  chk_high_gate: assert property (@(posedge clk) disable iff (reset) // R8
    !pf_s && !sel_s && !ub_s |=> !ram_select_high_out_n)
    else $error("high enable not passed");
  chk_low_gate: assert property (@(posedge clk) disable iff (reset) // R9
    $past(sel_s) || $past(lb_s) |-> ram_select_low_out_n)
    else $error("low enable without select");
  chk_wdog_restart: assert property (@(posedge clk) disable iff (reset) // R10
    !strobe_s |=> wdog_cnt == 0) else $error("watchdog not restarted");

  cov_pf_cycle:  cover property (@(posedge clk) disable iff (reset) $fell(pf_s));
  cov_button:    cover property (@(posedge clk) disable iff (reset) button_press);
  cov_wdog:      cover property (@(posedge clk) disable iff (reset) wdog_expire);
  cov_ram_write: cover property (@(posedge clk) disable iff (reset) !ram_select_low_out_n);
endmodule

//--- verif/cpusv_host.sv
// Host processor model: strobes the watchdog while out of reset
`timescale 1ns/10ps
module cpusv_host (
  // Clock, reset pin level and strobe enable
  input  wire logic clk,
  input  wire logic cpu_reset_n,
  input  wire logic strobe_on,
  // Strobe
  output logic      watchdog_strobe_n
);
  logic [3:0] div;
  initial begin
    div = 4'h0;
    watchdog_strobe_n = 1'b1;
  end
  always @(posedge clk) begin
    div <= div + 4'h1;
    watchdog_strobe_n <= !(strobe_on && cpu_reset_n && div == 4'h0);
  end
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the processor supervisor
`timescale 1ns/10ps
module tb_top;
  import cpusv_pkg::*;
  logic       clk, reset, power_fail, press, strobe_on, sel_n, ub_n, lb_n;
  logic       rst_out, rst_oe, strobe_n, high_n, low_n;
  logic [3:0] e;
  logic [3:0] notes[$];
  int         mismatches, checks, n;
  event       probe;
  wire logic  pin_n = !(rst_oe && !rst_out) && !press;
  cpusv_supervisor #(.TICK_DIVIDE(4), .STRETCH_COUNT(8), .DEBOUNCE_COUNT(2),
    .WATCHDOG_COUNT(10)) dut (.clk(clk), .reset(reset), .power_fail(power_fail),
    .cpu_reset_n_in(pin_n), .cpu_reset_n_out(rst_out), .cpu_reset_n_oe(rst_oe),
    .watchdog_strobe_n(strobe_n), .ram_select_in_n(sel_n), .upper_byte_enable_n(ub_n),
    .lower_byte_enable_n(lb_n), .ram_select_high_out_n(high_n),
    .ram_select_low_out_n(low_n));
  cpusv_host host (.clk(clk), .cpu_reset_n(pin_n), .strobe_on(strobe_on),
    .watchdog_strobe_n(strobe_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  task automatic summarize;
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic expect_oe(input logic o);
    notes.push_back({1'b0, o, power_fail ? 2'b11 : {sel_n | ub_n, sel_n | lb_n}});
    -> probe;
  endtask
  always @(probe) begin
    while (notes.size() > 0) begin
      e = notes.pop_front();
      checks++;
      if ({rst_out, rst_oe, high_n, low_n} !== e) begin
        $display("wrong value at %0t: got %h expected %h", $time,
          {rst_out, rst_oe, high_n, low_n}, e);
        mismatches++;
      end
    end
  end
  task automatic wait_oe(input logic v, input int lim);
    n = 0;
    while (rst_oe !== v) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        mismatches++;
        summarize();
      end
    end
  endtask
  task automatic in_range(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, lo);
      mismatches++;
    end
  endtask
  initial begin
    n = $urandom(32'h28f8b8da);
    mismatches = 0;
    checks = 0;
    reset = 1'b1;
    power_fail = 1'b0;
    press = 1'b0;
    strobe_on = 1'b1;
    {sel_n, ub_n, lb_n} = 3'b111;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    expect_oe(1'b1);
    wait_oe(1'b0, 60);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      {sel_n, ub_n, lb_n} <= 3'($urandom);
      power_fail <= (i >= 12);
      repeat (5) @(negedge clk);
      expect_oe(power_fail);
    end
    @(posedge clk);
    power_fail <= 1'b0;
    {sel_n, ub_n, lb_n} <= 3'b111;
    repeat (20) @(negedge clk);
    expect_oe(1'b1);
    wait_oe(1'b0, 40);
    in_range(n + 20, 33, 45);
    @(posedge clk);
    press <= 1'b1;
    repeat (2) @(posedge clk);
    press <= 1'b0;
    repeat (20) @(negedge clk);
    expect_oe(1'b0);
    @(posedge clk);
    press <= 1'b1;
    wait_oe(1'b1, 20);
    @(posedge clk);
    press <= 1'b0;
    strobe_on <= 1'b0;
    wait_oe(1'b0, 50);
    in_range(n + 1, 31, 40);
    wait_oe(1'b1, 60);
    in_range(n, 36, 50);
    @(posedge clk);
    strobe_on <= 1'b1;
    wait_oe(1'b0, 60);
    repeat (120) @(negedge clk);
    expect_oe(1'b0);
    summarize();
  end
endmodule
